/* verif/lbk_props.sv */
// port assertions for the loop-back frame generator
`timescale 1ns/1ps
module lbk_props
  import lbk_pkg::*;
#(
  parameter int LEN_W = 11
)(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // frame stream, returns, interrupt
  input wire tx_beat_t tx_beat_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic rx_frame_end_i,
  input wire logic rx_crc_err_i,
  input wire logic irq_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic [10:0] idx_r;
  // byte index inside the current frame, so field checks need no frame model
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      idx_r <= 11'h000;
    else if (tx_valid_o && tx_ready_i)
      idx_r <= tx_beat_o.eof ? 11'h000 : idx_r + 11'h001;
  end
  sequence s_start;
    reg_wr_i && reg_addr_i == 8'h44 && reg_wdata_i != 8'h00;
  endsequence
  sequence s_last;
    tx_valid_o && tx_ready_i && tx_beat_o.eof;
  endsequence
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not idle");
  a_run_start: assert property (s_start |-> ##2 (tx_valid_o && tx_beat_o.sof))
    else $error("run did not start");
  a_beat_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_beat_o))
    else $error("beat changed while stalled");
  a_sof_first: assert property (tx_valid_o && tx_beat_o.sof |-> idx_r == 11'h000)
    else $error("start flag off first byte");
  a_frame_len: assert property (tx_valid_o && tx_beat_o.eof |-> idx_r inside {11'h03b, 11'h5e9})
    else $error("bad frame length");
  a_type_high: assert property (tx_valid_o && idx_r == 11'h00c |-> tx_beat_o.data == 8'h08)
    else $error("type high byte wrong");
  a_type_low: assert property (tx_valid_o && idx_r == 11'h00d |-> tx_beat_o.data == 8'h00)
    else $error("type low byte wrong");
  a_frame_follow: assert property (s_last ##1 tx_valid_o |-> tx_beat_o.sof)
    else $error("beat after frame end is not a frame start");
  a_len_cap: assert property (tx_valid_o |-> idx_r <= 11'h5e9)
    else $error("frame overran");
endmodule : lbk_props
bind loopback_gen lbk_props #(.LEN_W(LEN_W)) u_lbk_props(.sys_clk_i(sys_clk_i),
  .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_beat_o(tx_beat_o),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .rx_frame_end_i(rx_frame_end_i),
  .rx_crc_err_i(rx_crc_err_i), .irq_o(irq_o));

/* verif/mac_partner.sv */
// far-side model: takes the frame stream and returns frame results
`timescale 1ns/1ps
module mac_partner
  import lbk_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // frame stream
  input wire tx_beat_t beat_i,
  input wire logic valid_i,
  output logic ready_o,
  // bench controls: stall, bad crc, extra returns
  input wire logic slow_i,
  input wire logic bad_i,
  input wire logic inj_i,
  // returned frame results
  output logic end_o,
  output logic crc_err_o
);
  logic [7:0] q[$];
  int nfr = 0;
  // accept bytes, stalling every other cycle when slow
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ready_o <= 1'b0;
      end_o <= 1'b0;
      crc_err_o <= 1'b0;
    end
    else
    begin
      ready_o <= slow_i ? !ready_o : 1'b1;
      end_o <= inj_i || (valid_i && ready_o && beat_i.eof);
      crc_err_o <= bad_i; // garbage unless end_o is high
      if (valid_i && ready_o)
      begin
        q.push_back(beat_i.data);
        if (beat_i.eof)
          nfr <= nfr + 1;
      end
    end
  end
endmodule : mac_partner

/* verif/testbench.sv */
// self-checking bench for the loop-back frame generator
`timescale 1ns/1ps
module testbench;
  import lbk_pkg::*;
  logic sys_clk_i, rstn_i, reg_wr_i, reg_rd_i, tx_ready_i, tx_valid_o, irq_o;
  logic rx_frame_end_i, rx_crc_err_i, slow, bad, inj;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  tx_beat_t tx_beat_o;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [7:0] sel [9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
  logic [7:0] sta [6] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hfe};
  loopback_gen u_loopback_gen(.sys_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .tx_beat_o, .tx_valid_o, .tx_ready_i, .rx_frame_end_i,
    .rx_crc_err_i, .irq_o);
  mac_partner u_mac_partner(.clk_i(sys_clk_i), .rstn_i(rstn_i), .beat_i(tx_beat_o),
    .valid_i(tx_valid_o), .ready_o(tx_ready_i), .slow_i(slow), .bad_i(bad), .inj_i(inj),
    .end_o(rx_frame_end_i), .crc_err_o(rx_crc_err_i));
  // 200 MHz clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(nm, e, reg_rdata_o);
  endtask : rdc
  task automatic irq_is(input logic e);
    repeat (2) @(posedge sys_clk_i);
    #1 chk("irq", {7'h00, e}, {7'h00, irq_o});
  endtask : irq_is
  // expected byte i of frame f for selector entry k
  function automatic logic [7:0] exb(int k, int f, int i);
    logic bc;
    bc = sel[k] inside {8'h02, 8'h04, 8'h20, 8'h40, 8'h80};
    if (i < 6)
      return bc ? 8'hff : (i < 5) ? sta[i] : sta[5] + 8'h01 + 8'(f);
    if (i < 12)
      return sta[i - 6];
    if (i < 14)
      return (i == 12) ? 8'h08 : 8'h00;
    if (k < 4)
      return i[0] ? 8'haa : 8'h55;
    if (k < 8)
      return 8'h0f;
    return i[0] ? 8'h00 : 8'hff;
  endfunction : exb
  task automatic t_regs();
    rdc(8'h44, 8'h07, "loop count");
    rdc(8'h45, 8'h00, "pattern");
    wr(8'h46, 8'h5a);
    rdc(8'h46, 8'h00, "crc count");
    wr(8'h45, 8'h3c);
    rdc(8'h45, 8'h3c, "pattern");
    rdc(8'h30, 8'h00, "unmapped");
    wr(8'h44, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    chk("valid", 8'h00, {7'h00, tx_valid_o});
    $display("register test done");
  endtask : t_regs
  // every selector code, two frames each, last address byte wraps
  task automatic t_frames();
    int base;
    int len;
    for (int a = 0; a < 6; a++)
      wr(8'h52 + 8'(a), sta[a]);
    for (int k = 0; k < 9; k++)
    begin
      len = (sel[k] inside {8'h01, 8'h04, 8'h10, 8'h40, 8'h80}) ? 1514 : 60;
      slow <= k[0];
      u_mac_partner.q.delete();
      base = u_mac_partner.nfr;
      wr(8'h45, sel[k]);
      wr(8'h44, 8'h02);
      for (int i = 0; i < 20000 && u_mac_partner.nfr < base + 2; i++)
        @(posedge sys_clk_i);
      if (u_mac_partner.nfr < base + 2)
      begin
        n_mismatch++;
        results();
      end
      for (int f = 0; f < 2; f++)
        for (int i = 0; i < len; i++)
          chk("frame byte", exb(k, f, i), u_mac_partner.q.pop_front());
      chk("extra bytes", 8'h00, 8'(u_mac_partner.q.size()));
      rdc(8'h62, 8'h00, "frames left");
    end
    $display("frame test done");
  endtask : t_frames
  task automatic t_crc();
    rdc(8'h46, 8'h00, "crc count");
    bad <= 1'b1;
    inj <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    inj <= 1'b0;
    rdc(8'h46, 8'h03, "crc count");
    inj <= 1'b1;
    repeat (260) @(posedge sys_clk_i);
    inj <= 1'b0;
    rdc(8'h46, 8'hff, "crc count");
    wr(8'h44, 8'h00);
    rdc(8'h46, 8'h00, "crc count");
    @(posedge sys_clk_i);
    inj <= 1'b1;
    fork
      wr(8'h44, 8'h00);
      @(posedge sys_clk_i) inj <= 1'b0;
    join
    rdc(8'h46, 8'h01, "crc count");
    bad <= 1'b0;
    $display("crc counter test done");
  endtask : t_crc
  task automatic t_irq();
    rdc(8'h60, 8'h03, "irq status");
    irq_is(1'b0);
    wr(8'h61, 8'h02);
    irq_is(1'b1);
    wr(8'h60, 8'h02);
    irq_is(1'b0);
    wr(8'h61, 8'h01);
    irq_is(1'b1);
    wr(8'h60, 8'h01);
    irq_is(1'b0);
    rdc(8'h60, 8'h00, "irq status");
    $display("interrupt test done");
  endtask : t_irq
  // reset in mid-run drops the frame and restores register defaults
  task automatic t_reset();
    wr(8'h44, 8'h05);
    repeat (20) @(posedge sys_clk_i);
    #1 chk("valid mid-run", 8'h01, {7'h00, tx_valid_o});
    @(posedge sys_clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 chk("valid in reset", 8'h00, {7'h00, tx_valid_o});
    @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rdc(8'h44, 8'h07, "loop count");
    rdc(8'h62, 8'h00, "frames left");
    $display("reset test done");
  endtask : t_reset
  // main sequence
  initial
  begin
    rstn_i = 1'b0;
    {reg_wr_i, reg_rd_i, slow, bad, inj} = 5'h00;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_frames();
    t_crc();
    t_irq();
    t_reset();
    results();
  end
endmodule : testbench

/* verilog/lbk_map.svh */
// register offsets, reset values and frame constants of the loop-back generator
`ifndef LBK_MAP_SVH
`define LBK_MAP_SVH
`define LBK_ADR_COUNT 8'h44
`define LBK_ADR_PATTERN 8'h45
`define LBK_ADR_CRC_ERR 8'h46
`define LBK_ADR_STA_FIRST 8'h52
`define LBK_ADR_STA_LAST 8'h57
`define LBK_ADR_IRQ_STS 8'h60
`define LBK_ADR_IRQ_MASK 8'h61
`define LBK_ADR_RUN_STS 8'h62
`define LBK_RST_COUNT 8'h07
`define LBK_RST_PATTERN 8'h00
`define LBK_RST_STA 8'h00
`define LBK_RST_CRC 8'h00
`define LBK_CRC_MAX 8'hff
`define LBK_LEN_SHORT 11'h03c
`define LBK_LEN_LONG 11'h5ea
`define LBK_IDX_TYPE_HI 11'h00c
`define LBK_IDX_TYPE_LO 11'h00d
`define LBK_IDX_SA 11'h006
`define LBK_IDX_PAYLOAD 11'h00e
`define LBK_TYPE_HI 8'h08
`define LBK_TYPE_LO 8'h00
`define LBK_BCAST_BYTE 8'hff
`define LBK_SEL_55_SU 8'h00
`define LBK_SEL_55_LU 8'h01
`define LBK_SEL_55_SB 8'h02
`define LBK_SEL_55_LB 8'h04
`define LBK_SEL_0F_SU 8'h08
`define LBK_SEL_0F_LU 8'h10
`define LBK_SEL_0F_SB 8'h20
`define LBK_SEL_0F_LB 8'h40
`define LBK_SEL_FF_LB 8'h80
`define LBK_IRQ_DONE 0
`define LBK_IRQ_CRC 1
`endif

/* verilog/lbk_pkg.sv */
// types shared by the loop-back test-frame generator
package lbk_pkg;
  typedef enum logic [1:0] {
    PAT_55AA = 2'h0,
    PAT_0F0F = 2'h1,
    PAT_FF00 = 2'h2
  } pattern_t;

  typedef struct packed {
    logic bcast;
    logic long_frame;
    pattern_t pat;
  } frame_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic sof;
    logic eof;
  } tx_beat_t;

  // gray order along idle -> send -> next
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_NEXT = 2'b11
  } gen_state_t;
endpackage : lbk_pkg

/* verilog/loopback_gen.sv */
// loop-back test frame generator and crc-error counter of the maintenance sub-layer
`timescale 1ns/1ps
`include "lbk_map.svh"
//
// Behaviour
// R1: selector codes 00h, 01h, 02h and 04h send 55AA frames: 64 unicast, 1518 unicast, 64 and 1518 broadcast.
// R2: one-hot selector bits 3 to 6 send 0F0F frames: 64 unicast, 1518 unicast, 64 and 1518 broadcast.
// R3: selector bit 7 alone sends 1518-byte broadcast frames with an FF00 payload.
// R4: software writes only the nine defined selector codes; other values give no promised frame.
// R5: the destination is station bytes 52h to 56h followed by the byte at 57h plus one.
// R6: each later frame of a run steps the last destination byte by one more.
// R7: the source address is station bytes 52h to 57h, last byte unmodified.
// R8: every frame carries type/length 0800h after the source address.
// R9: each returned loop-back frame with a bad crc adds one to an 8-bit read-only counter.
// R10: writing zero to the loop count register at 44h clears the crc-error counter.
// R11: a nonzero write to the loop count register starts a run of that many frames, seven by default.
// R12: the crc-error counter holds at 255 instead of wrapping until it is cleared.
module loopback_gen
  import lbk_pkg::*;
#(
  parameter int LEN_W = 11
)(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // frame stream toward the mac, fcs appended downstream
  output tx_beat_t tx_beat_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // returned frame results from the receive mac
  input wire logic rx_frame_end_i,
  input wire logic rx_crc_err_i,
  // interrupt
  output logic irq_o
);

  // software registers
  logic [7:0] loop_count_r;
  logic [7:0] pattern_sel_r;
  logic [7:0] crc_err_count_r;
  logic [5:0][7:0] station_r;
  logic [1:0] irq_sts_r;
  logic [1:0] irq_mask_r;
  logic [7:0] reg_rdata_r;
  logic irq_r;

  // generator state
  gen_state_t state_r;
  logic [LEN_W-1:0] idx_r;
  logic [7:0] frames_left_r;
  logic [7:0] dlast_r;
  frame_cfg_t cfg_r;
  tx_beat_t beat_r;
  logic tx_valid_r;

  // decoded strobes
  logic wr_count;
  logic start_run;
  logic clr_counters;
  logic crc_event;
  logic done_event;
  logic load_beat;
  logic [LEN_W-1:0] frame_len;
  logic wr_pattern;
  logic wr_sta;
  logic wr_irq_sts;
  logic wr_irq_mask;
  logic last_byte;
  logic [1:0] irq_set;

  // selector code to frame shape; undefined codes fall back to the first code
  function automatic frame_cfg_t decode_sel(input logic [7:0] sel);
    frame_cfg_t c;
    c = '{bcast: 1'b0, long_frame: 1'b0, pat: PAT_55AA};
    case (sel)
      `LBK_SEL_55_SU: c = '{bcast: 1'b0, long_frame: 1'b0, pat: PAT_55AA}; // R1
      `LBK_SEL_55_LU: c = '{bcast: 1'b0, long_frame: 1'b1, pat: PAT_55AA}; // R1
      `LBK_SEL_55_SB: c = '{bcast: 1'b1, long_frame: 1'b0, pat: PAT_55AA}; // R1
      `LBK_SEL_55_LB: c = '{bcast: 1'b1, long_frame: 1'b1, pat: PAT_55AA}; // R1
      `LBK_SEL_0F_SU: c = '{bcast: 1'b0, long_frame: 1'b0, pat: PAT_0F0F}; // R2
      `LBK_SEL_0F_LU: c = '{bcast: 1'b0, long_frame: 1'b1, pat: PAT_0F0F}; // R2
      `LBK_SEL_0F_SB: c = '{bcast: 1'b1, long_frame: 1'b0, pat: PAT_0F0F}; // R2
      `LBK_SEL_0F_LB: c = '{bcast: 1'b1, long_frame: 1'b1, pat: PAT_0F0F}; // R2
      `LBK_SEL_FF_LB: c = '{bcast: 1'b1, long_frame: 1'b1, pat: PAT_FF00}; // R3
      default: c = '{bcast: 1'b0, long_frame: 1'b0, pat: PAT_55AA}; // R4
    endcase
    return c;
  endfunction : decode_sel

  // station window decode, shared by the write path and the read mux
  function automatic logic sta_hit(input logic [7:0] addr);
    return (addr >= `LBK_ADR_STA_FIRST) && (addr <= `LBK_ADR_STA_LAST);
  endfunction : sta_hit

  // byte slot of a station register; meaningful only where sta_hit holds
  function automatic logic [2:0] sta_pos(input logic [7:0] addr);
    return 3'(addr - `LBK_ADR_STA_FIRST);
  endfunction : sta_pos

  // payload byte; the patterns repeat in pairs, so the low index bit picks the half
  function automatic logic [7:0] payload_byte(
    input logic odd,
    input pattern_t pat
  );
    logic [7:0] b;
    b = 8'h00;
    case (pat)
      PAT_55AA: b = odd ? 8'haa : 8'h55; // R1
      PAT_0F0F: b = 8'h0f; // R2
      default: b = odd ? 8'h00 : 8'hff; // R3
    endcase
    return b;
  endfunction : payload_byte

  // byte at a given position of the frame, fcs excluded
  function automatic logic [7:0] frame_byte(
    input logic [LEN_W-1:0] idx,
    input frame_cfg_t cfg,
    input logic [5:0][7:0] sta,
    input logic [7:0] dlast
  );
    logic [7:0] b;
    logic [2:0] pos;
    b = 8'h00;
    pos = 3'h0;
    if (idx < `LBK_IDX_SA)
    begin
      pos = idx[2:0];
      // broadcast hides the stepped byte, which still advances per frame
      if (cfg.bcast)
        b = `LBK_BCAST_BYTE;
      else if (pos == 3'h5)
        b = dlast; // R5
      else
        b = sta[pos]; // R5
    end
    else if (idx < `LBK_IDX_TYPE_HI)
    begin
      pos = 3'(idx - `LBK_IDX_SA);
      b = sta[pos]; // R7
    end
    else if (idx == `LBK_IDX_TYPE_HI)
      b = `LBK_TYPE_HI; // R8
    else if (idx == `LBK_IDX_TYPE_LO)
      b = `LBK_TYPE_LO; // R8
    else
      b = payload_byte(idx[0], cfg.pat); // payload opens at an even index, high byte first
    return b;
  endfunction : frame_byte

  // strobe decode
  assign wr_count = reg_wr_i && (reg_addr_i == `LBK_ADR_COUNT);
  assign start_run = wr_count && (reg_wdata_i != 8'h00); // R11
  assign clr_counters = wr_count && (reg_wdata_i == 8'h00); // R10
  assign crc_event = rx_frame_end_i && rx_crc_err_i;
  assign load_beat = (state_r == ST_SEND) && (!tx_valid_r || tx_ready_i);
  assign done_event = (state_r == ST_NEXT) && (frames_left_r == 8'h01);
  assign frame_len = cfg_r.long_frame ? `LBK_LEN_LONG : `LBK_LEN_SHORT;
  assign wr_pattern = reg_wr_i && (reg_addr_i == `LBK_ADR_PATTERN);
  assign wr_sta = reg_wr_i && sta_hit(reg_addr_i);
  assign wr_irq_sts = reg_wr_i && (reg_addr_i == `LBK_ADR_IRQ_STS);
  assign wr_irq_mask = reg_wr_i && (reg_addr_i == `LBK_ADR_IRQ_MASK);
  // last byte of the current frame, fcs excluded
  assign last_byte = (idx_r == frame_len - 1'b1);
  // status set terms, one bit per event
  assign irq_set = {crc_event, done_event};

  // loop count register; software value, not the running count
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      loop_count_r <= `LBK_RST_COUNT;
    else if (wr_count)
      loop_count_r <= reg_wdata_i;
  end

  // pattern selector, sampled at each run start
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pattern_sel_r <= `LBK_RST_PATTERN;
    else if (wr_pattern)
      pattern_sel_r <= reg_wdata_i;
  end

  // station bytes, read live by the builder; rewriting them mid-run mixes addresses
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      station_r <= {6{`LBK_RST_STA}};
    else if (wr_sta)
      station_r[sta_pos(reg_addr_i)] <= reg_wdata_i;
  end

  // crc-error counter; an error in the clearing cycle still counts
  // saturating, so a full count still means at least that many bad frames
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      crc_err_count_r <= `LBK_RST_CRC;
    else if (clr_counters)
      crc_err_count_r <= crc_event ? 8'h01 : `LBK_RST_CRC; // R10
    else if (crc_event && crc_err_count_r != `LBK_CRC_MAX) // R12
      crc_err_count_r <= crc_err_count_r + 8'h01; // R9
  end

  // generator sequencing
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r <= ST_IDLE;
      idx_r <= '0;
      frames_left_r <= 8'h00;
      dlast_r <= 8'h00;
      cfg_r <= '{bcast: 1'b0, long_frame: 1'b0, pat: PAT_55AA};
    end
    else if (start_run)
    begin
      // a new count restarts the run from its first frame
      state_r <= ST_SEND;
      idx_r <= '0;
      frames_left_r <= reg_wdata_i; // R11
      dlast_r <= station_r[5] + 8'h01; // R5
      cfg_r <= decode_sel(pattern_sel_r);
    end
    else
    begin
      case (state_r)
        ST_SEND:
        begin
          if (load_beat)
          begin
            idx_r <= idx_r + 1'b1;
            if (last_byte)
              state_r <= ST_NEXT;
          end
        end
        // one load slot left idle between frames; the mac still drains the eof beat
        ST_NEXT:
        begin
          idx_r <= '0;
          frames_left_r <= frames_left_r - 8'h01;
          dlast_r <= dlast_r + 8'h01; // R6
          state_r <= (frames_left_r == 8'h01) ? ST_IDLE : ST_SEND;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // output beat register; holds while the mac stalls
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      beat_r <= '{data: 8'h00, sof: 1'b0, eof: 1'b0};
      tx_valid_r <= 1'b0;
    end
    else if (load_beat)
    begin
      beat_r.data <= frame_byte(idx_r, cfg_r, station_r, dlast_r);
      // frame marks ride with the byte they mark
      beat_r.sof <= (idx_r == '0);
      beat_r.eof <= last_byte;
      tx_valid_r <= 1'b1;
    end
    else if (tx_ready_i)
      tx_valid_r <= 1'b0;
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      irq_sts_r <= 2'h0;
    else
    begin
      if (wr_irq_sts)
        irq_sts_r <= (irq_sts_r & ~reg_wdata_i[1:0]) | irq_set;
      else
        irq_sts_r <= irq_sts_r | irq_set;
    end
  end

  // interrupt mask
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      irq_mask_r <= 2'h0;
    else if (wr_irq_mask)
      irq_mask_r <= reg_wdata_i[1:0];
  end

  // level interrupt, one cycle behind the status
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_sts_r & irq_mask_r);
  end

  // read data, valid the cycle after the strobe and zero otherwise
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      reg_rdata_r <= 8'h00;
    else if (!reg_rd_i)
      reg_rdata_r <= 8'h00;
    else if (reg_addr_i == `LBK_ADR_COUNT)
      reg_rdata_r <= loop_count_r;
    else if (reg_addr_i == `LBK_ADR_PATTERN)
      reg_rdata_r <= pattern_sel_r;
    else if (reg_addr_i == `LBK_ADR_CRC_ERR)
      reg_rdata_r <= crc_err_count_r; // R9
    else if (sta_hit(reg_addr_i))
      reg_rdata_r <= station_r[sta_pos(reg_addr_i)];
    else if (reg_addr_i == `LBK_ADR_IRQ_STS)
      reg_rdata_r <= {6'h00, irq_sts_r};
    else if (reg_addr_i == `LBK_ADR_IRQ_MASK)
      reg_rdata_r <= {6'h00, irq_mask_r};
    // frames still owed, so software can poll a run to its end
    else if (reg_addr_i == `LBK_ADR_RUN_STS)
      reg_rdata_r <= frames_left_r;
    // unmapped addresses read zero
    else
      reg_rdata_r <= 8'h00;
  end

  // every output is a bare flip-flop, no logic behind the pins
  assign reg_rdata_o = reg_rdata_r;
  assign tx_beat_o = beat_r;
  assign tx_valid_o = tx_valid_r;
  assign irq_o = irq_r;

endmodule : loopback_gen
